/* core/sdr_readout.sv */
// diagnostic readout top: fault latch, frame check, and link control
// assumes stage codes and heat sensors arrive asynchronously from the
// analog side; the spi master leaves 40 ns after select falls before
// its first clock and keeps select high at least 40 ns between frames
`timescale 1ns/10ps
`default_nettype none
module sdr_readout
   import sdr_pkg::*;
#(
   parameter logic [7:0] OP_HEALTH = 8'h00,  // arbitrary opcode value
   parameter logic [7:0] OP_SCON   = 8'h01,  // arbitrary opcode value
   parameter logic [7:0] OP_MUX    = 8'h02   // arbitrary opcode value
) (
   // core clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst,
   // device reset pin
   input  wire logic                    reset_pin_n,
   // serial link
   input  wire logic                    sclk,
   input  wire logic                    cs_n,
   input  wire logic                    si,
   output logic                         so_o,
   output logic                         so_oe,
   // analog fault detection
   input  wire logic [2*NUM_STAGES-1:0] channel_code_bits,
   input  wire logic [NUM_STAGES-1:0]   heat_sense,
   // read-back registers kept elsewhere
   input  wire logic [7:0]              serial_switch_state,
   input  wire logic [7:0]              control_source,
   // general fault and command hand-off
   output logic                         fault_n_q,
   output logic                         cmd_commit_q,
   output logic [15:0]                  cmd_word_q,
   output logic                         frame_error_q
);
   localparam int SW = 2 + NUM_STAGES + 2 * NUM_STAGES;
   localparam logic [SW-1:0] SYNC_RST =
      {2'b11, {NUM_STAGES{1'b0}}, {2*NUM_STAGES{1'b1}}};

   logic                    rstpin_s;
   logic                    cs_s;
   logic [NUM_STAGES-1:0]   heat_s;
   logic [2*NUM_STAGES-1:0] code_s;
   logic                    cs_prev_q;
   logic                    cs_rise;
   logic                    cs_fall;
   logic                    link_clr_q;
   logic [4:0]              fcnt;
   logic [15:0]             rx;
   logic                    frame_ok;
   logic                    clear_now;
   logic                    wipe;
   logic [1:0]              code_q [NUM_STAGES];
   logic                    ot_q;
   logic                    err_q;
   logic                    any_fault_now;
   logic [2*NUM_STAGES-1:0] code_p_q;
   logic [NUM_STAGES-1:0]   code_steady;
   sdr_snap_t               snap_q;
   logic                    so_link;
   logic                    so_oe_link;

   // reset pin, select, heat and code levels pass two flops before core use; sclk and si go straight to the link
   sdr_sync #(
      .W       (SW),
      .RST_VAL (SYNC_RST)
   ) u_sync (
      .clk (clk),
      .rst (rst),
      .d   ({reset_pin_n, cs_n, heat_sense, channel_code_bits}),
      .q   ({rstpin_s, cs_s, heat_s, code_s})
   );

   // select edges as seen by the core clock
   always_ff @(posedge clk) begin
      if (rst) cs_prev_q <= 1'b1;
      else cs_prev_q <= cs_s;
   end

   assign cs_rise = cs_s && !cs_prev_q;
   assign cs_fall = !cs_s && cs_prev_q;

   // link counters are static once select is high; read them at the
   // rise, then hold the link in reset until the next select fall
   always_ff @(posedge clk) begin
      if (rst) link_clr_q <= 1'b1;
      else if (cs_rise) link_clr_q <= 1'b1;
      else if (cs_fall) link_clr_q <= 1'b0;
   end

   assign frame_ok  = (fcnt == FRAME_BITS);
   assign clear_now = cs_rise && frame_ok &&
                      (rx[15:8] == OP_HEALTH);
   assign wipe      = rst || !rstpin_s;

   // last cycle's codes; a code counts only once both of its bits have
   // agreed on two clocks, since the two bits cross separately and a
   // change from 11 to 00 may pass 10 or 01 on the way
   always_ff @(posedge clk) begin
      if (rst) code_p_q <= {2*NUM_STAGES{1'b1}};
      else code_p_q <= code_s;
   end

   // per-stage code latch: first steady fault sticks; a clear reloads
   // the present code so a fault seen in the clearing cycle is kept,
   // or reopens the stage so a code still settling is taken once steady
   for (genvar i = 0; i < NUM_STAGES; i++) begin : g_stage
      assign code_steady[i] = (code_s[2*i +: 2] == code_p_q[2*i +: 2]);
      always_ff @(posedge clk) begin
         if (wipe) code_q[i] <= CODE_OK;
         else if (clear_now && code_steady[i])
            code_q[i] <= code_s[2*i +: 2];
         else if (clear_now) code_q[i] <= CODE_OK;
         else if (code_q[i] == CODE_OK && code_steady[i])
            code_q[i] <= code_s[2*i +: 2];
      end
   end

   always_comb begin
      any_fault_now = 1'b0;
      for (int i = 0; i < NUM_STAGES; i++) begin
         if (code_s[2*i +: 2] != CODE_OK) any_fault_now = 1'b1;
      end
   end

   // common flags, held high-active inside and inverted on the wire
   always_ff @(posedge clk) begin
      if (wipe) begin
         ot_q  <= 1'b0;
         err_q <= 1'b0;
      end else if (clear_now) begin
         ot_q  <= |heat_s;
         err_q <= any_fault_now;
      end else begin
         ot_q  <= ot_q | (|heat_s);
         err_q <= err_q | any_fault_now;
      end
   end

   // snapshot tracks the latch while idle and freezes while selected;
   // this is what makes the bytes safe to read on the serial clock
   always_ff @(posedge clk) begin
      if (rst) begin
         snap_q <= '{hi: HI_RESET, diag: LO_RESET,
                     scon: LO_RESET, mux: LO_RESET};
      end else if (cs_s) begin
         snap_q.hi   <= {Z_FILL, !err_q, !ot_q,
                         code_q[5], code_q[4]};
         snap_q.diag <= {code_q[3], code_q[2],
                         code_q[1], code_q[0]};
         snap_q.scon <= serial_switch_state;
         snap_q.mux  <= control_source;
      end
   end

   // frame result: commands commit at the select rise, bad counts flag
   always_ff @(posedge clk) begin
      if (rst) begin
         cmd_commit_q  <= 1'b0;
         cmd_word_q    <= 16'h0000;
         frame_error_q <= 1'b0;
      end else begin
         cmd_commit_q  <= cs_rise && frame_ok;
         frame_error_q <= cs_rise && !frame_ok;
         if (cs_rise && frame_ok) cmd_word_q <= rx;
      end
   end

   // general fault pin mirrors the latched error flag
   always_ff @(posedge clk) begin
      if (rst) fault_n_q <= 1'b1;
      else fault_n_q <= !err_q;
   end

   sdr_link #(
      .OP_SCON (OP_SCON),
      .OP_MUX  (OP_MUX)
   ) u_link (
      .sclk     (sclk),
      .cs_n     (cs_n),
      .si       (si),
      .so_q     (so_link),
      .so_oe_q  (so_oe_link),
      .link_clr (link_clr_q),
      .snap     (snap_q),
      .fcnt_q   (fcnt),
      .rx_q     (rx)
   );

   // link flops drive the pin directly
   assign so_o  = so_link;
   assign so_oe = so_oe_link;

   chk_fault_held: assert property (
      @(posedge clk) disable iff (rst)
      (code_q[0] != CODE_OK && !clear_now && rstpin_s) |=>
      $stable(code_q[0]))
      else $error("latched code changed without clear");

   chk_clear_loads: assert property (
      @(posedge clk) disable iff (rst)
      (clear_now && rstpin_s) |=>
      (code_q[5] == ($past(code_steady[5]) ? $past(code_s[11:10])
                                           : CODE_OK)) &&
      (ot_q == $past(|heat_s)))
      else $error("clear did not reload store");

   chk_no_clear_bad: assert property (
      @(posedge clk) disable iff (rst)
      (cs_rise && !frame_ok && rstpin_s && code_q[1] != CODE_OK) |=>
      (code_q[1] == $past(code_q[1])))
      else $error("invalid frame cleared store");

   chk_pin_reset: assert property (
      @(posedge clk) disable iff (rst)
      !rstpin_s |=> (code_q[2] == CODE_OK) && !ot_q && !err_q)
      else $error("reset pin did not wipe store");

   chk_heat_or: assert property (
      @(posedge clk) disable iff (rst)
      ((|heat_s) && rstpin_s) |=> ot_q ##1 (ot_q || $past(clear_now)))
      else $error("heat not latched");

   chk_err_any: assert property (
      @(posedge clk) disable iff (rst)
      (any_fault_now && rstpin_s) |=> err_q ##1 !fault_n_q)
      else $error("stage fault missed by error flag");

   chk_hi_layout: assert property (
      @(posedge clk) disable iff (rst)
      $past(cs_s) |->
      (snap_q.hi[ERR_BIT] == !$past(err_q)) &&
      (snap_q.hi[OT_BIT] == !$past(ot_q)) &&
      (snap_q.hi[3:0] == {$past(code_q[5]), $past(code_q[4])}))
      else $error("high byte layout wrong");

   chk_lo_layout: assert property (
      @(posedge clk) disable iff (rst)
      $past(cs_s) |->
      (snap_q.diag == {$past(code_q[3]), $past(code_q[2]),
                       $past(code_q[1]), $past(code_q[0])}))
      else $error("low byte layout wrong");

   chk_commit_edge: assert property (
      @(posedge clk) disable iff (rst)
      (cs_rise && frame_ok) |=> cmd_commit_q && (cmd_word_q == $past(rx))
      ##1 !cmd_commit_q)
      else $error("command not committed at select rise");

   chk_bad_count: assert property (
      @(posedge clk) disable iff (rst)
      (cs_rise && !frame_ok) |=> frame_error_q && !cmd_commit_q)
      else $error("bad count not flagged");

   chk_frozen_snap: assert property (
      @(posedge clk) disable iff (rst)
      (!cs_s && !cs_prev_q) |=> $stable(snap_q))
      else $error("snapshot moved during frame");

   chk_err_held: assert property (
      @(posedge clk) disable iff (rst)
      (err_q && !clear_now && rstpin_s) |=> err_q)
      else $error("error flag dropped without clear");

   chk_ot_held: assert property (
      @(posedge clk) disable iff (rst)
      (ot_q && !clear_now && rstpin_s) |=> ot_q)
      else $error("heat flag dropped without clear");

   chk_other_op: assert property (
      @(posedge clk) disable iff (rst)
      (cs_rise && frame_ok && rx[15:8] != OP_HEALTH && rstpin_s &&
       code_q[4] != CODE_OK) |=> $stable(code_q[4]))
      else $error("other instruction cleared store");

   chk_commit_valid: assert property (
      @(posedge clk) disable iff (rst)
      cmd_commit_q |-> $past(cs_rise) && $past(frame_ok))
      else $error("commit without valid frame end");

   chk_error_pulse: assert property (
      @(posedge clk) disable iff (rst)
      frame_error_q |=> !frame_error_q)
      else $error("frame error pulse too long");

   chk_link_held: assert property (
      @(posedge clk) disable iff (rst)
      (cs_s && cs_prev_q) |-> link_clr_q)
      else $error("link counters free while deselected");

   chk_float_idle: assert property (
      @(posedge clk) disable iff (rst)
      (cs_s && cs_prev_q) |-> !so_oe)
      else $error("so driven while deselected");

   chk_steady_load: assert property (
      @(posedge clk) disable iff (rst)
      (code_q[2] == CODE_OK && code_steady[2] && !clear_now &&
       rstpin_s) |=> (code_q[2] == $past(code_s[5:4])))
      else $error("steady code not latched");

   chk_skip_unsteady: assert property (
      @(posedge clk) disable iff (rst)
      (code_q[2] == CODE_OK && !code_steady[2] && !clear_now &&
       rstpin_s) |=> (code_q[2] == CODE_OK))
      else $error("code latched while changing");
endmodule : sdr_readout
`default_nettype wire

/* core/sdr_pkg.sv */
// constants and carrier types for the switch diagnostic readout
// assumes a 100 MHz core clock and an spi link clocked by its master
`default_nettype none
package sdr_pkg;
   localparam int          NUM_STAGES  = 6;
   localparam logic [4:0]  FRAME_BITS  = 5'h10;  // valid frame length
   localparam logic [4:0]  LO_START    = 5'h08;  // rises before low byte
   localparam logic [4:0]  FIRST_DRIVE = 5'h02;  // rises before so drives
   localparam logic [1:0]  CODE_OK     = 2'h3;
   localparam logic [1:0]  CODE_OVLD   = 2'h2;
   localparam logic [1:0]  CODE_OPEN   = 2'h1;
   localparam logic [1:0]  CODE_GND    = 2'h0;
   localparam logic [7:0]  HI_RESET    = 8'hff;
   localparam logic [7:0]  LO_RESET    = 8'hff;
   localparam int          ERR_BIT     = 5;
   localparam int          OT_BIT      = 4;
   localparam logic [1:0]  Z_FILL      = 2'h3;   // value behind float bits

   typedef enum logic [1:0] {
      LO_HEALTH = 2'b00,
      LO_SCON   = 2'b01,
      LO_MUX    = 2'b10
   } sdr_lo_sel_t;

   // bytes offered to the link, frozen while a frame runs
   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] diag;
      logic [7:0] scon;
      logic [7:0] mux;
   } sdr_snap_t;
endpackage : sdr_pkg
`default_nettype wire

/* core/sdr_sync.sv */
// two flip-flop synchroniser for a group of independent levels
// assumes each bit is a level with no relation to its neighbours
`timescale 1ns/10ps
`default_nettype none
module sdr_sync #(
   parameter int             W       = 1,
   parameter logic [W-1:0]   RST_VAL = '0
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // levels
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q
);
   logic [W-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= RST_VAL;
         q      <= RST_VAL;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : sdr_sync
`default_nettype wire

/* core/sdr_link.sv */
// spi side of the readout, clocked by the master's serial clock
// assumes snap, and the opcodes, are static while select is low
`timescale 1ns/10ps
`default_nettype none
module sdr_link
   import sdr_pkg::*;
#(
   parameter logic [7:0] OP_SCON = 8'h01,
   parameter logic [7:0] OP_MUX  = 8'h02
) (
   // serial pins
   input  wire logic        sclk,
   input  wire logic        cs_n,
   input  wire logic        si,
   output logic             so_q,
   output logic             so_oe_q,
   // from core domain
   input  wire logic        link_clr,
   input  wire sdr_snap_t   snap,
   // to core domain, read only while select is high
   output logic [4:0]       fcnt_q,
   output logic [15:0]      rx_q
);
   logic [4:0]  rcnt_q;
   logic [7:0]  lo_q;
   sdr_lo_sel_t sel_q;
   sdr_lo_sel_t sel_now;
   logic [7:0]  lo_now;

   // falling edges are counted and si sampled; saturate to keep long
   // frames invalid
   always_ff @(negedge sclk or posedge link_clr) begin
      if (link_clr) begin
         fcnt_q <= 5'h00;
         rx_q   <= 16'h0000;
      end else if (!cs_n) begin
         if (fcnt_q != 5'h1f) fcnt_q <= fcnt_q + 5'h01;
         rx_q <= {rx_q[14:0], si};
      end
   end

   // instruction byte is complete after eight falls
   always_comb begin
      if (rx_q[7:0] == OP_SCON) sel_now = LO_SCON;
      else if (rx_q[7:0] == OP_MUX) sel_now = LO_MUX;
      else sel_now = LO_HEALTH;
      case (sel_now)
         LO_SCON: lo_now = snap.scon;
         LO_MUX:  lo_now = snap.mux;
         default: lo_now = snap.diag;
      endcase
   end

   // rise k presents frame bit 16-k; select high floats so at once
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         rcnt_q  <= 5'h00;
         so_q    <= 1'b1;
         so_oe_q <= 1'b0;
         lo_q    <= LO_RESET;
         sel_q   <= LO_HEALTH;
      end else begin
         if (rcnt_q != FRAME_BITS) rcnt_q <= rcnt_q + 5'h01;
         if (rcnt_q == LO_START) begin
            lo_q  <= lo_now;
            sel_q <= sel_now;
            so_q  <= lo_now[7];
         end else if (rcnt_q < LO_START) begin
            so_q <= snap.hi[3'(5'h07 - rcnt_q)];
         end else if (rcnt_q < FRAME_BITS) begin
            so_q <= lo_q[3'(5'h0f - rcnt_q)];
         end else begin
            so_q <= 1'b1;
         end
         // bits 15 and 14 are never driven
         so_oe_q <= (rcnt_q >= FIRST_DRIVE) &&
                    (rcnt_q < FRAME_BITS);
      end
   end

   chk_float_head: assert property (
      @(posedge sclk) disable iff (cs_n)
      (rcnt_q <= FIRST_DRIVE) |-> !so_oe_q)
      else $error("so driven during float bits");

   chk_drive_body: assert property (
      @(posedge sclk) disable iff (cs_n)
      (rcnt_q > FIRST_DRIVE && rcnt_q < FRAME_BITS) |-> so_oe_q)
      else $error("so not driven in frame body");

   chk_first_byte: assert property (
      @(posedge sclk) disable iff (cs_n)
      (rcnt_q == FIRST_DRIVE) |=> (so_q == snap.hi[ERR_BIT])
      ##1 (so_q == snap.hi[OT_BIT]))
      else $error("high byte not first");

   chk_second_byte: assert property (
      @(posedge sclk) disable iff (cs_n)
      (rcnt_q == 5'h09 && sel_q == LO_HEALTH) |->
      (so_q == snap.diag[7]) && (lo_q == snap.diag))
      else $error("health byte not second");
endmodule : sdr_link
`default_nettype wire

/* test/sdr_master.sv */
// spi master model that reads the diagnostic bytes out of the readout
// assumes the bench calls frame() from one process at a time
`timescale 1ns/10ps
`default_nettype none
module sdr_master (
   // core clock, used to place select changes off the sampling edge
   input  wire logic clk,
   // serial pins
   output logic      sclk,
   output logic      cs_n,
   output logic      si,
   input  wire logic so_o,
   input  wire logic so_oe
);
   // link idles with clock low and select high
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      si   = 1'b0;
   end

   // one frame of n clocks at 48 ns; so is read on each of the first 16 falling clocks
   task automatic frame(input logic [15:0] tx, input int n,
                        output logic [15:0] rx, output logic [15:0] oe);
      int k;
      rx = '0;
      oe = '0;
      @(negedge clk);
      cs_n = 1'b0;
      #48;  // lead time above the 40 ns the readout needs
      for (k = 1; k <= n; k++) begin
         sclk = 1'b1;
         si   = (k <= 16) ? tx[16-k] : 1'b0;
         #24;
         sclk = 1'b0;
         if (k <= 16) begin
            rx[16-k] = so_o;
            oe[16-k] = so_oe;
         end
         #24;
      end
      @(negedge clk);
      cs_n = 1'b1;
      si   = ~si;  // released line shows no stale value
      repeat (6) @(negedge clk);  // select high well above 4 clocks
   endtask : frame
endmodule : sdr_master
`default_nettype wire

/* test/switch_diagnostic_readout_tb.sv */
// self-checking bench for the diagnostic readout
// assumes sdr_master as the spi partner; no other bus reaches the bytes
`timescale 1ns/10ps
`default_nettype none
module switch_diagnostic_readout_tb;
   import sdr_pkg::*;
   localparam logic [7:0]  OP_H   = 8'h00;
   localparam logic [7:0]  OP_S   = 8'h01;
   localparam logic [7:0]  OP_M   = 8'h02;
   localparam logic [11:0] ALL_OK = 12'hfff;
   localparam logic [11:0] MIXED  = {CODE_OPEN, CODE_OVLD, CODE_OK,
                                     CODE_OVLD, CODE_OPEN, CODE_GND};
   localparam logic [13:0] OK14   = {6'h3f, 8'hff};
   localparam logic [5:0]  MIX_HI = 6'b01_0110;
   localparam logic [13:0] MIX_OT = {6'b00_0110, 8'he4};
   logic        clk, rst, reset_pin_n, sclk, cs_n, si, so_o, so_oe;
   logic [11:0] codes;
   logic [5:0]  heat;
   logic [7:0]  sw_state, ctl_src;
   logic        fault_n_q, cmd_commit_q, frame_error_q;
   logic [15:0] cmd_word_q;
   int          num_errors = 0;
   int          tests_run = 0;
   int          n_commit = 0;
   int          n_ferr = 0;

   sdr_readout #(.OP_HEALTH(OP_H), .OP_SCON(OP_S), .OP_MUX(OP_M))
      i_sdr_readout (
      .clk(clk), .rst(rst), .reset_pin_n(reset_pin_n), .sclk(sclk),
      .cs_n(cs_n), .si(si), .so_o(so_o), .so_oe(so_oe),
      .channel_code_bits(codes), .heat_sense(heat),
      .serial_switch_state(sw_state), .control_source(ctl_src),
      .fault_n_q(fault_n_q), .cmd_commit_q(cmd_commit_q),
      .cmd_word_q(cmd_word_q), .frame_error_q(frame_error_q));

   sdr_master i_sdr_master (
      .clk(clk), .sclk(sclk), .cs_n(cs_n), .si(si), .so_o(so_o),
      .so_oe(so_oe));

   // core clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // count one-cycle pulses so frames can be judged afterwards
   always @(posedge clk) begin
      if (cmd_commit_q === 1'b1) n_commit++;
      if (frame_error_q === 1'b1) n_ferr++;
   end

   task automatic print_verdict;
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : print_verdict

   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // one frame plus the judgement of commit, error pulse and enable
   task automatic xfer(input logic [7:0] op, input int n,
                       output logic [15:0] rx);
      logic [15:0] oe;
      int          c0;
      int          e0;
      c0 = n_commit;
      e0 = n_ferr;
      i_sdr_master.frame({op, 8'ha5}, n, rx, oe);
      if (n == 16) check("so_oe per bit", oe, 16'h3fff);
      check("commits", 16'(n_commit - c0), 16'((n == 16) ? 1 : 0));
      check("frame errors", 16'(n_ferr - e0), 16'(n != 16));
      if (n == 16) check("command word", cmd_word_q, {op, 8'ha5});
   endtask : xfer

   // valid frame; the two float bits are left out of the compare
   task automatic rd(input logic [7:0] op, input logic [13:0] exp);
      logic [15:0] rx;
      xfer(op, 16, rx);
      check("so bytes", {2'h0, rx[13:0]}, {2'h0, exp});
   endtask : rd

   // drive the analog side, then let the synchronisers settle
   task automatic apply(input logic [11:0] c, input logic [5:0] h);
      @(negedge clk);
      codes = c;
      heat  = h;
      repeat (10) @(negedge clk);
   endtask : apply

   task automatic t_reset;
      check("so_oe idle", {15'h0, so_oe}, 16'h0);
      check("fault idle", {15'h0, fault_n_q}, 16'h1);
      rd(OP_H, OK14);
   endtask : t_reset

   task automatic t_codes;
      apply(MIXED, 6'h04);
      check("fault set", {15'h0, fault_n_q}, 16'h0);
      apply(ALL_OK, 6'h00);
      check("fault held", {15'h0, fault_n_q}, 16'h0);
      rd(OP_H, MIX_OT);
      check("fault cleared", {15'h0, fault_n_q}, 16'h1);
      rd(OP_H, OK14);
   endtask : t_codes

   task automatic t_select;
      apply(MIXED, 6'h00);
      apply(ALL_OK, 6'h00);
      rd(OP_S, {MIX_HI, sw_state});
      rd(OP_M, {MIX_HI, ctl_src});
      rd(OP_H, {MIX_HI, 8'he4});
      rd(OP_H, OK14);
   endtask : t_select

   task automatic t_count;
      logic [15:0] rx;
      apply(MIXED, 6'h00);
      apply(ALL_OK, 6'h00);
      xfer(OP_H, 15, rx);
      xfer(OP_H, 17, rx);
      check("fault after bad", {15'h0, fault_n_q}, 16'h0);
      rd(OP_H, {MIX_HI, 8'he4});
      rd(OP_H, OK14);
   endtask : t_count

   task automatic t_heat;
      apply(ALL_OK, 6'h20);
      apply(ALL_OK, 6'h00);
      check("fault heat", {15'h0, fault_n_q}, 16'h1);
      rd(OP_H, {6'b10_1111, 8'hff});
      rd(OP_H, OK14);
   endtask : t_heat

   task automatic t_pin;
      apply(MIXED, 6'h01);
      apply(ALL_OK, 6'h00);
      check("fault pin pre", {15'h0, fault_n_q}, 16'h0);
      reset_pin_n = 1'b0;
      repeat (6) @(negedge clk);
      reset_pin_n = 1'b1;
      repeat (6) @(negedge clk);
      check("fault pin post", {15'h0, fault_n_q}, 16'h1);
      rd(OP_H, OK14);
   endtask : t_pin

   // main sequence; reset held six cycles
   initial begin
      rst         = 1'b1;
      reset_pin_n = 1'b1;
      codes       = ALL_OK;
      heat        = 6'h00;
      sw_state    = 8'h5a;
      ctl_src     = 8'hc3;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      t_reset();
      t_codes();
      t_select();
      t_count();
      t_heat();
      t_pin();
      print_verdict();
   end

   // watchdog: the run needs about 14 us, so 300 us means a hang
   initial begin
      #300_000;
      num_errors++;
      print_verdict();
   end
endmodule : switch_diagnostic_readout_tb
`default_nettype wire
